// [core/pmx_consts.svh]
// Address map, field positions, masks and reset values of the pad mux bank
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// Window base and word offsets inside it
`define PMX_BASE_ADDR        32'h4000_0000
`define PMX_BASE_MASK        32'hffff_ff00
`define PMX_OFF_FSEL_LO      8'h20
`define PMX_OFF_FSEL_HI      8'h24
`define PMX_OFF_ROUTE        8'h28
`define PMX_OFF_DRIVE        8'h2c
`define PMX_OFF_PULL_LO      8'h30
`define PMX_OFF_PULL_HI      8'h34
`define PMX_OFF_WAKE         8'h3c

// Writable bits of each word; everything else is reserved
`define PMX_WMASK_FULL       32'hffff_ffff
`define PMX_WMASK_ROUTE      32'hf800_00fb
`define PMX_WMASK_DRIVE      32'h7fff_ffff
`define PMX_WMASK_PULL_HI    32'h3fff_ffff

// Reset values
`define PMX_RST_FSEL         32'h0000_0000
`define PMX_RST_ROUTE        32'h0000_0080
`define PMX_RST_DRIVE        32'h0000_0000
`define PMX_RST_PULL_LO      32'haaaa_aaaa
`define PMX_RST_PULL_HI      32'h2aaa_aaaa
`define PMX_RST_WAKE         32'h0000_0000
`define PMX_RST_PAD_GPIO     31'h7fff_ff3f

// Field positions in the high select word
`define PMX_BIT_FLASH_REL    31
`define PMX_BIT_TEST_SWD     30
`define PMX_BIT_TEST_PINS    29
// Field positions in the route word
`define PMX_TEST_SRC_HI      31
`define PMX_TEST_SRC_LO      27
`define PMX_BIT_CLKB_SEL     7
`define PMX_BIT_CLKA_SEL     6
`define PMX_BIT_UART2_RT     5
`define PMX_BIT_I2C_RT       4
`define PMX_BIT_ADCT_RT      3
`define PMX_BIT_SPI1_RT      1
`define PMX_BIT_SPI2_RT      0

// Bus response codes
`define PMX_RESP_OKAY        2'b00
`define PMX_RESP_SLVERR      2'b10

`endif

// [core/pmx_pkg.sv]
// Types shared by the pad mux bank
package pmx_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        PMX_REG_NONE, PMX_REG_FSEL_LO, PMX_REG_FSEL_HI, PMX_REG_ROUTE,
        PMX_REG_DRIVE, PMX_REG_PULL_LO, PMX_REG_PULL_HI, PMX_REG_WAKE
    } pmx_reg_t;

    // Two-bit pad pull code
    typedef enum logic [1:0] {
        PMX_PULL_HIZ = 2'b00, PMX_PULL_DOWN = 2'b01, PMX_PULL_UP = 2'b10, PMX_PULL_RSVD = 2'b11
    } pmx_pull_t;

    // Whole state of the bank
    typedef struct packed {
        logic        aw_full;
        logic [31:0] aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] fsel_lo;
        logic [31:0] fsel_hi;
        logic [31:0] route;
        logic [31:0] drive;
        logic [31:0] pull_lo;
        logic [31:0] pull_hi;
        logic [31:0] wake;
        logic [15:0] gpio_s1;
        logic [15:0] gpio_s2;
        logic        wakeup_req;
        logic [30:0] pad_is_gpio;
    } pmx_state_t;

endpackage : pmx_pkg

// [core/pmx_top.sv]
// Pad mux, pad electrical and GPIO wakeup configuration bank with AXI4-Lite slave
// Behaviour
// - Window at 0x40000000, select words 20h-28h
// - Selector bits split 31-0 and 60-32, reset zero
// - High word bit 31 releases flash pads
// - High word bit 30 enables debug-shared test
// - High word bit 29 enables 13 test pins
// - Route word bits 31-27 pick test source
// - Route bit 7 picks clock pin B source
// - Route bit 6 picks clock pin A source
// - Route bit 5 moves second UART inputs
// - Route bit 4 moves I2C clock and data
// - Route bit 3 picks converter trigger pad
// - Route bit 1 moves first SPI unit
// - Route bit 0 moves second SPI unit
// - Drive word one bit per pad, bit31 zero
// - Two-bit pull code per pad
// - Pull words reset to pull-up everywhere
// - Wake word low half enables GPIO wakeup
// - Wake word high half sets active level
// - Two-bit select code per pad (P3_4 one bit), 00 GPIO except pads 6 and 7 where 01 is GPIO
//
// Decided for this implementation: the AXI4-Lite register port.
`include "pmx_consts.svh"

module pmx_top
    import pmx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] gpio_pin_in,
    output logic [60:0]      pad_function_select,
    output logic [30:0]      pad_is_gpio,
    output logic             flash_pads_released,
    output logic             test_swd_enable,
    output logic             test_pins_enable,
    output logic [4:0]       test_source,
    output logic             clock_output_pin_b_sel,
    output logic             clock_output_pin_a_sel,
    output logic             second_uart_route,
    output logic             i2c_route,
    output logic             converter_trigger_route,
    output logic             first_spi_route,
    output logic             second_spi_route,
    output logic [30:0]      pad_drive_strength,
    output logic [61:0]      pad_pull_select,
    output logic [15:0]      wakeup_enable,
    output logic [15:0]      wakeup_level_low,
    output logic             wakeup_req
);

    pmx_state_t st_r;
    pmx_state_t st_nxt;
    logic       wr_fire;
    logic       rd_fire;
    pmx_reg_t   wr_sel;
    pmx_reg_t   rd_sel;

    // Full address decode; anything outside the seven words is unmapped
    function automatic pmx_reg_t reg_decode(input logic [31:0] addr);
        pmx_reg_t r;
        r = PMX_REG_NONE;
        if ((addr & `PMX_BASE_MASK) == `PMX_BASE_ADDR) begin
            case (addr[7:0])
                `PMX_OFF_FSEL_LO: r = PMX_REG_FSEL_LO;
                `PMX_OFF_FSEL_HI: r = PMX_REG_FSEL_HI;
                `PMX_OFF_ROUTE:   r = PMX_REG_ROUTE;
                `PMX_OFF_DRIVE:   r = PMX_REG_DRIVE;
                `PMX_OFF_PULL_LO: r = PMX_REG_PULL_LO;
                `PMX_OFF_PULL_HI: r = PMX_REG_PULL_HI;
                `PMX_OFF_WAKE:    r = PMX_REG_WAKE;
                default:          r = PMX_REG_NONE;
            endcase
        end
        return r;
    endfunction : reg_decode

    // Byte-lane merge limited to writable bits
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb,
                                               input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return ((old & ~m) | (data & m)) & wmask;
    endfunction : lane_merge

    // Select code of one pad; P3_4 owns a single bit
    function automatic logic [1:0] pad_code(input logic [60:0] sel, input int pad);
        logic [1:0] c;
        c = 2'b00;
        if (pad < 28) begin
            c = sel[2*pad +: 2];
        end else if (pad == 28) begin
            c = {1'b0, sel[56]};
        end else if (pad == 29) begin
            c = sel[58:57];
        end else begin
            c = sel[60:59];
        end
        return c;
    endfunction : pad_code

    // Read value of a decoded register
    function automatic logic [31:0] reg_read(input pmx_state_t s, input pmx_reg_t r);
        logic [31:0] v;
        case (r)
            PMX_REG_FSEL_LO: v = s.fsel_lo;
            PMX_REG_FSEL_HI: v = s.fsel_hi;
            PMX_REG_ROUTE:   v = s.route & `PMX_WMASK_ROUTE;
            PMX_REG_DRIVE:   v = s.drive & `PMX_WMASK_DRIVE;
            PMX_REG_PULL_LO: v = s.pull_lo;
            PMX_REG_PULL_HI: v = s.pull_hi & `PMX_WMASK_PULL_HI;
            PMX_REG_WAKE:    v = s.wake;
            default:         v = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_read

    // Handshake qualifiers; a write commits only once address and data are both held
    assign wr_fire = clk_en & st_r.aw_full & st_r.w_full & ~st_r.bvalid;
    assign rd_fire = clk_en & st_r.arready & s_axi_arvalid;
    assign wr_sel  = reg_decode(st_r.aw_addr);
    assign rd_sel  = reg_decode(s_axi_araddr);

    // Next-state logic; clk_en low leaves every field as it is
    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            // Address and data are taken in either order and held
            if (st_r.awready && s_axi_awvalid) begin
                st_nxt.aw_full = 1'b1;
                st_nxt.aw_addr = s_axi_awaddr;
            end
            if (st_r.wready && s_axi_wvalid) begin
                st_nxt.w_full = 1'b1;
                st_nxt.w_data = s_axi_wdata;
                st_nxt.w_strb = s_axi_wstrb;
            end
            if (st_r.bvalid && s_axi_bready) begin
                st_nxt.bvalid = 1'b0;
            end
            if (wr_fire) begin
                st_nxt.aw_full = 1'b0;
                st_nxt.w_full  = 1'b0;
                st_nxt.bvalid  = 1'b1;
                st_nxt.bresp   = (wr_sel == PMX_REG_NONE) ? `PMX_RESP_SLVERR : `PMX_RESP_OKAY;
                case (wr_sel)
                    PMX_REG_FSEL_LO: st_nxt.fsel_lo = lane_merge(st_r.fsel_lo, st_r.w_data,
                                         st_r.w_strb, `PMX_WMASK_FULL);
                    PMX_REG_FSEL_HI: st_nxt.fsel_hi = lane_merge(st_r.fsel_hi, st_r.w_data,
                                         st_r.w_strb, `PMX_WMASK_FULL);
                    PMX_REG_ROUTE:   st_nxt.route = lane_merge(st_r.route, st_r.w_data,
                                         st_r.w_strb, `PMX_WMASK_ROUTE);
                    PMX_REG_DRIVE:   st_nxt.drive = lane_merge(st_r.drive, st_r.w_data,
                                         st_r.w_strb, `PMX_WMASK_DRIVE);
                    PMX_REG_PULL_LO: st_nxt.pull_lo = lane_merge(st_r.pull_lo, st_r.w_data,
                                         st_r.w_strb, `PMX_WMASK_FULL);
                    PMX_REG_PULL_HI: st_nxt.pull_hi = lane_merge(st_r.pull_hi, st_r.w_data,
                                         st_r.w_strb, `PMX_WMASK_PULL_HI);
                    PMX_REG_WAKE:    st_nxt.wake = lane_merge(st_r.wake, st_r.w_data,
                                         st_r.w_strb, `PMX_WMASK_FULL);
                    default: ;
                endcase
            end
            // Ready stays low while a word is parked or a response waits
            st_nxt.awready = ~st_nxt.aw_full & ~st_nxt.bvalid;
            st_nxt.wready  = ~st_nxt.w_full & ~st_nxt.bvalid;
            // Read path: one outstanding read, data captured at the address edge
            if (st_r.rvalid && s_axi_rready) begin
                st_nxt.rvalid  = 1'b0;
                st_nxt.arready = 1'b1;
            end
            if (rd_fire) begin
                st_nxt.rvalid  = 1'b1;
                st_nxt.arready = 1'b0;
                st_nxt.rdata   = reg_read(st_r, rd_sel);
                st_nxt.rresp   = (rd_sel == PMX_REG_NONE) ? `PMX_RESP_SLVERR : `PMX_RESP_OKAY;
            end
            // Pins come from outside: two flops before the wakeup compare
            st_nxt.gpio_s1 = gpio_pin_in;
            st_nxt.gpio_s2 = st_r.gpio_s1;
            // Level-sensitive wakeup, polarity 0 means active high
            st_nxt.wakeup_req = |(st_r.wake[15:0] & (st_r.gpio_s2 ^ st_r.wake[31:16]));
            // GPIO is code 00, except the two debug pads where it is code 01
            for (int p = 0; p < 31; p++) begin
                st_nxt.pad_is_gpio[p] = (pad_code({st_r.fsel_hi[28:0], st_r.fsel_lo}, p) ==
                                         ((p == 6 || p == 7) ? 2'b01 : 2'b00));
            end
        end
    end

    // Single state register; synchronous reset beats the clock enable
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_r             <= '0;
            st_r.awready     <= 1'b1;
            st_r.wready      <= 1'b1;
            st_r.arready     <= 1'b1;
            st_r.fsel_lo     <= `PMX_RST_FSEL;
            st_r.fsel_hi     <= `PMX_RST_FSEL;
            st_r.route       <= `PMX_RST_ROUTE;
            st_r.drive       <= `PMX_RST_DRIVE;
            st_r.pull_lo     <= `PMX_RST_PULL_LO;
            st_r.pull_hi     <= `PMX_RST_PULL_HI;
            st_r.wake        <= `PMX_RST_WAKE;
            st_r.pad_is_gpio <= `PMX_RST_PAD_GPIO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus outputs straight from the state register
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

    // Pad function and test controls
    assign pad_function_select = {st_r.fsel_hi[28:0], st_r.fsel_lo};
    assign pad_is_gpio         = st_r.pad_is_gpio;
    assign flash_pads_released = st_r.fsel_hi[`PMX_BIT_FLASH_REL];
    assign test_swd_enable     = st_r.fsel_hi[`PMX_BIT_TEST_SWD];
    assign test_pins_enable    = st_r.fsel_hi[`PMX_BIT_TEST_PINS];
    assign test_source         = st_r.route[`PMX_TEST_SRC_HI:`PMX_TEST_SRC_LO];

    // Clock source selects only; the clock mux itself sits in the clock tree
    assign clock_output_pin_b_sel = st_r.route[`PMX_BIT_CLKB_SEL];
    assign clock_output_pin_a_sel = st_r.route[`PMX_BIT_CLKA_SEL];

    // Peripheral placement switches read by the pad crossbar
    assign second_uart_route       = st_r.route[`PMX_BIT_UART2_RT];
    assign i2c_route               = st_r.route[`PMX_BIT_I2C_RT];
    assign converter_trigger_route = st_r.route[`PMX_BIT_ADCT_RT];
    assign first_spi_route         = st_r.route[`PMX_BIT_SPI1_RT];
    assign second_spi_route        = st_r.route[`PMX_BIT_SPI2_RT];

    // Electrical pad controls and wakeup fields
    assign pad_drive_strength = st_r.drive[30:0];
    assign pad_pull_select    = {st_r.pull_hi[29:0], st_r.pull_lo};
    assign wakeup_enable      = st_r.wake[15:0];
    assign wakeup_level_low   = st_r.wake[31:16];
    assign wakeup_req         = st_r.wakeup_req;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_rst_vals;
        !$past(nrst) |-> (st_r.pull_lo == `PMX_RST_PULL_LO) && (st_r.pull_hi == `PMX_RST_PULL_HI)
                         && clock_output_pin_b_sel && !clock_output_pin_a_sel;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");

    property p_fsel_write;
        logic [31:0] d;
        (wr_fire && wr_sel == PMX_REG_FSEL_LO && st_r.w_strb == 4'hf, d = st_r.w_data)
            |=> (pad_function_select[31:0] == d) && s_axi_bvalid;
    endproperty
    a_fsel_write: assert property (p_fsel_write) else $error("select word not written");

    property p_rsvd_zero;
        ((st_r.route & ~`PMX_WMASK_ROUTE) == 32'h0000_0000) && !st_r.drive[31]
            && (st_r.pull_hi[31:30] == 2'b00);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

    property p_drive_write;
        (wr_fire && wr_sel == PMX_REG_DRIVE && st_r.w_strb[0])
            |=> pad_drive_strength[7:0] == $past(st_r.w_data[7:0]);
    endproperty
    a_drive_write: assert property (p_drive_write) else $error("drive not written");

    property p_wakeup;
        $past(clk_en, 2) && $past(clk_en)
            |-> wakeup_req == $past(|(wakeup_enable & (st_r.gpio_s2 ^ wakeup_level_low)));
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup level wrong");

    property p_unmapped;
        (wr_fire && wr_sel == PMX_REG_NONE) |=> s_axi_bvalid && (s_axi_bresp == `PMX_RESP_SLVERR);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");

    property p_read_route;
        (rd_fire && rd_sel == PMX_REG_ROUTE)
            |=> s_axi_rvalid && (s_axi_rdata == $past(st_r.route & `PMX_WMASK_ROUTE));
    endproperty
    a_read_route: assert property (p_read_route) else $error("route read wrong");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("response dropped");

    property p_gpio_code;
        $past(clk_en) && $past(pad_function_select[1:0]) == 2'b00 |-> pad_is_gpio[0];
    endproperty
    a_gpio_code: assert property (p_gpio_code) else $error("pad 0 gpio code wrong");

    // Freeze, handshake, reserved-bit, wakeup and pin path checks
    property p_freeze;
        !clk_en
            |=> $stable(st_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved");

    property p_busy;
        s_axi_bvalid
            |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready early");

    property p_rhold;
        s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read dropped");

    property p_ar_busy;
        s_axi_rvalid
            |-> !s_axi_arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("ar ready early");

    property p_pull_top;
        (rd_fire && rd_sel == PMX_REG_PULL_HI)
            |=> s_axi_rdata[31:30] == 2'b00;
    endproperty
    a_pull_top: assert property (p_pull_top) else $error("pull top set");

    property p_wake_off;
        $past(clk_en) && $past(wakeup_enable) == 16'h0000
            |-> !wakeup_req;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("wakeup while off");

    property p_sync;
        $past(nrst, 2) && $past(nrst) && $past(clk_en, 2) && $past(clk_en)
            |-> st_r.gpio_s2 == $past(gpio_pin_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync wrong");

    c_write:  cover property (wr_fire && wr_sel != PMX_REG_NONE);
    c_read:   cover property (rd_fire && rd_sel == PMX_REG_PULL_LO);
    c_wake:   cover property ($rose(wakeup_req));
    c_badadr: cover property (wr_fire && wr_sel == PMX_REG_NONE);
    c_frozen: cover property (!clk_en);

endmodule : pmx_top

// [dv/pmx_pad_model.sv]
// Pad-side model: drives the sixteen GPIO input pin levels seen by the bank
module pmx_pad_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] level_req,
    output logic [15:0]      gpio_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins move just after a rising edge
    // Peripherals stay idle here, so no mux change meets an enabled unit
    initial gpio_pin_in = 16'h0000;
    always @(posedge core_clk) begin
        gpio_pin_in <= level_req;
    end
endmodule : pmx_pad_model

// [dv/pmx_top_bench.sv]
// Self-checking bench for the pad mux bank
`include "pmx_consts.svh"

`define CHK(what, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
end

module pmx_top_bench import pmx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        nrst, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, flash_pads_released, test_swd_enable;
    logic        test_pins_enable, clock_output_pin_b_sel, clock_output_pin_a_sel;
    logic        second_uart_route, i2c_route, converter_trigger_route, first_spi_route;
    logic        second_spi_route, wakeup_req;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] gpio_pin_in, level_req, wakeup_enable, wakeup_level_low;
    logic [60:0] pad_function_select;
    logic [30:0] pad_is_gpio, pad_drive_strength;
    logic [61:0] pad_pull_select;
    logic [4:0]  test_source;
    int          num_errors = 0;
    int          total_checks = 0;
    integer      seed = 32'hd04f77cd;
    logic [31:0] m [7];
    logic [7:0]  offs [7] = '{`PMX_OFF_FSEL_LO, `PMX_OFF_FSEL_HI, `PMX_OFF_ROUTE,
                              `PMX_OFF_DRIVE, `PMX_OFF_PULL_LO, `PMX_OFF_PULL_HI, `PMX_OFF_WAKE};
    logic [31:0] wmsk [7] = '{`PMX_WMASK_FULL, `PMX_WMASK_FULL, `PMX_WMASK_ROUTE,
                              `PMX_WMASK_DRIVE, `PMX_WMASK_FULL, `PMX_WMASK_PULL_HI,
                              `PMX_WMASK_FULL};
    logic [31:0] rstv [7] = '{`PMX_RST_FSEL, `PMX_RST_FSEL, `PMX_RST_ROUTE, `PMX_RST_DRIVE,
                              `PMX_RST_PULL_LO, `PMX_RST_PULL_HI, `PMX_RST_WAKE};
    logic [31:0] bad [3]  = '{32'h4000_0038, 32'h4000_0000, 32'h5000_0020};

    pmx_top dut (
        .core_clk, .nrst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_pin_in,
        .pad_function_select, .pad_is_gpio, .flash_pads_released, .test_swd_enable,
        .test_pins_enable, .test_source, .clock_output_pin_b_sel, .clock_output_pin_a_sel,
        .second_uart_route, .i2c_route, .converter_trigger_route, .first_spi_route,
        .second_spi_route, .pad_drive_strength, .pad_pull_select, .wakeup_enable,
        .wakeup_level_low, .wakeup_req
    );

    pmx_pad_model pads (.core_clk, .level_req, .gpio_pin_in);

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks: %0d, errors: %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Write: address and data offered together, each dropped once taken
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] resp);
        int n;
        n = 0;
        resp = 2'b11;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) `CHK("write answer", 1'b1, 1'b0)
    endtask : bus_write

    // Read: rready held until rvalid
    task automatic bus_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        int n;
        d = 32'h0;
        resp = 2'b11;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) `CHK("read answer", 1'b1, 1'b0)
    endtask : bus_read

    // Read back and compare
    task automatic chk_reg(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        bus_read(`PMX_BASE_ADDR + offs[i], d, r);
        `CHK("read resp", `PMX_RESP_OKAY, r)
        `CHK("read data", m[i], d)
    endtask : chk_reg

    // Byte-lane write into model and design
    task automatic put_reg(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] bm;
        logic [1:0]  r;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wmsk[i];
        bus_write(`PMX_BASE_ADDR + offs[i], d, s, r);
        `CHK("write resp", `PMX_RESP_OKAY, r)
        m[i] = (m[i] & ~bm) | (d & bm);
        chk_reg(i);
    endtask : put_reg

    // Pads in GPIO mode; P3_4 has a one-bit field, so later pads shift by one
    function automatic logic [30:0] exp_gpio(input logic [60:0] sel);
        logic [1:0] c;
        for (int p = 0; p < 31; p++) begin
            c = (p < 28) ? sel[2*p +: 2] : (p == 28) ? {1'b0, sel[56]} : sel[2*p-1 +: 2];
            exp_gpio[p] = (c == ((p == 6 || p == 7) ? 2'b01 : 2'b00));
        end
    endfunction : exp_gpio

    // Every output compared with the model
    task automatic check_outputs();
        `CHK("fsel", {m[1][28:0], m[0]}, pad_function_select)
        `CHK("flash", m[1][31], flash_pads_released)
        `CHK("swd test", m[1][30], test_swd_enable)
        `CHK("test pins", m[1][29], test_pins_enable)
        `CHK("test src", m[2][31:27], test_source)
        `CHK("clk b", m[2][7], clock_output_pin_b_sel)
        `CHK("clk a", m[2][6], clock_output_pin_a_sel)
        `CHK("uart", m[2][5], second_uart_route)
        `CHK("i2c", m[2][4], i2c_route)
        `CHK("adct", m[2][3], converter_trigger_route)
        `CHK("spi a", m[2][1], first_spi_route)
        `CHK("spi b", m[2][0], second_spi_route)
        `CHK("drive", m[3][30:0], pad_drive_strength)
        `CHK("pull", {m[5][29:0], m[4]}, pad_pull_select)
        `CHK("wake en", m[6][15:0], wakeup_enable)
        `CHK("wake lvl", m[6][31:16], wakeup_level_low)
        `CHK("wake", |(m[6][15:0] & (level_req ^ m[6][31:16])), wakeup_req)
        `CHK("gpio mode", exp_gpio({m[1][28:0], m[0]}), pad_is_gpio)
    endtask : check_outputs

    // Reset, then every value at reset
    task automatic do_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        m = rstv;
        @(posedge core_clk);
        check_outputs();
        for (int i = 0; i < 7; i++) chk_reg(i);
    endtask : do_reset

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        clk_en = 1'b1;
        level_req = 16'h0000;
        do_reset();
        // Random words and byte lanes across the map
        for (int k = 0; k < 60; k++) begin
            put_reg($unsigned($random(seed)) % 7, 32'($random(seed)), 4'($random(seed)));
            check_outputs();
        end
        // All ones, all zeros
        for (int i = 0; i < 7; i++) begin
            put_reg(i, 32'hffff_ffff, 4'hf);
            check_outputs();
            put_reg(i, 32'h0000_0000, 4'hf);
        end
        // Unmapped addresses refuse and change nothing
        for (int j = 0; j < 3; j++) begin
            bus_write(bad[j], 32'hffff_ffff, 4'hf, r);
            `CHK("bad write", `PMX_RESP_SLVERR, r)
            bus_read(bad[j], d, r);
            `CHK("bad resp", `PMX_RESP_SLVERR, r)
            `CHK("bad data", 32'h0, d)
        end
        for (int i = 0; i < 7; i++) chk_reg(i);
        // Wakeup: random enables, levels and pins
        for (int k = 0; k < 24; k++) begin
            put_reg(6, 32'($random(seed)), 4'hf);
            level_req <= 16'($random(seed));
            repeat (6) @(posedge core_clk);
            check_outputs();
        end
        // Frozen enable holds the wakeup output while the pins flip
        clk_en    <= 1'b0;
        level_req <= ~level_req;
        repeat (6) @(posedge core_clk);
        `CHK("frozen wake", |(m[6][15:0] & (~level_req ^ m[6][31:16])), wakeup_req)
        clk_en    <= 1'b1;
        // Second reset in mid-run
        do_reset();
        wrap_up();
    end

    // Watchdog: the sequence needs far fewer than 20000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("[FAIL] watchdog expected end seen hang");
        wrap_up();
    end
endmodule : pmx_top_bench
